// file: rtl/gpio_pin_nv_config.sv
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module gpio_pin_nv_config #(
  parameter int DEB_CYC = gpio_cfg_pkg::LONG_DEB_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // classic wishbone slave, byte address
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [17:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             irq_o,
  // pad
  input  wire logic        pad_in_i,
  output logic             pad_out_o,
  output logic             pad_oe_o,
  output logic             pull_up_en_o,
  output logic             pull_down_en_o,
  output logic             supply_domain_select_o,
  // sources for output functions
  input  wire logic        osc_32k_i,
  input  wire logic        on_state_i,
  input  wire logic        sleep_state_i,
  input  wire logic        state_change_i,
  input  wire logic [1:0]  voltage_scaling_done_i,
  input  wire logic [1:0]  ext_power_enable_i,
  input  wire logic        system_supply_good_i,
  input  wire logic        converter_power_good_i,
  input  wire logic        aux_reset_i,
  // requests for input functions, active-level adjusted
  output logic             gpio_in_o,
  output logic             power_toggle_req_o,
  output logic             sleep_wake_req_o,
  output logic             sleep_req_o,
  output logic             power_on_req_o,
  output logic             watchdog_reset_o,
  output logic      [1:0]  voltage_scaling_sel_o,
  output logic      [1:0]  hw_enable_o,
  output logic      [1:0]  hw_control_o
);

  // a zero-length filter could never settle
  if (DEB_CYC < 1) begin : g_deb_check
    $error("DEB_CYC must be at least 1");
  end

  // register bus
  // every access, mapped or not, is
  // answered one cycle after it is taken

  // stored state
  logic [15:0] gpio6_nv_pin_config_r;
  logic        status_r;
  logic        mask_r;
  logic        gpio_out_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        edge_ev;
  logic        in_level;

  // decode of the request on the bus

  logic        bus_req;
  logic [15:0] word_idx;
  logic [15:0] byte_mask;
  logic        wr_en;
  logic        hit_cfg;
  logic        hit_status;
  logic        hit_mask;
  logic        hit_data;

  // one access per request; ack drops in the cycle after it was given
  assign bus_req    = cyc_i && stb_i && !ack_r;
  assign word_idx   = adr_i[17:2];
  assign byte_mask  = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wr_en      = bus_req && we_i;
  assign hit_cfg    = (word_idx == gpio_cfg_pkg::CFG_IDX);
  assign hit_status = (word_idx == gpio_cfg_pkg::STATUS_IDX);
  assign hit_mask   = (word_idx == gpio_cfg_pkg::MASK_IDX);
  assign hit_data   = (word_idx == gpio_cfg_pkg::DATA_IDX);

  // acknowledge every address; unmapped ones read zero and ignore writes
  // ack_r masks bus_req, so a request
  // held past its ack is not taken twice
  // and ack never stands two cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end

  // read data captured at the taking edge
  // and held, so dat_o stands while ack
  // is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      unique case (1'b1)
        hit_cfg:    rdata_r <= {16'h0000, gpio6_nv_pin_config_r};
        hit_status: rdata_r <= {31'h0000_0000, status_r};
        hit_mask:   rdata_r <= {31'h0000_0000, mask_r};
        hit_data:   rdata_r <= {30'h0000_0000, in_level, gpio_out_r};
        default:    rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ack and read data leave from flops
  assign ack_o = ack_r;
  assign dat_o = rdata_r;

  // configuration word; low threshold bits are not implemented and read zero
  // sel_i picks the byte lanes written;
  // the threshold sits in a supply monitor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio6_nv_pin_config_r <= gpio_cfg_pkg::CFG_RESET;
    end else if (wr_en && hit_cfg) begin
      gpio6_nv_pin_config_r <= (gpio6_nv_pin_config_r & ~(byte_mask & gpio_cfg_pkg::CFG_WMASK))
                             | (dat_i[15:0] & byte_mask & gpio_cfg_pkg::CFG_WMASK);
    end
  end

  // mask and software output value
  // both sit in byte lane 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r     <= 1'b0;
      gpio_out_r <= 1'b0;
    end else if (wr_en && sel_i[0]) begin
      if (hit_mask) mask_r <= dat_i[gpio_cfg_pkg::EDGE_EV_BIT];
      if (hit_data) gpio_out_r <= dat_i[gpio_cfg_pkg::DATA_OUT_BIT];
    end
  end

  // sticky edge status, write one to clear; a new edge wins over the clear
  // so an edge on the clear cycle is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= 1'b0;
    end else if (edge_ev) begin
      status_r <= 1'b1;
    end else if (wr_en && hit_status && sel_i[0] && dat_i[gpio_cfg_pkg::EDGE_EV_BIT]) begin
      status_r <= 1'b0;
    end
  end

  // level output; software clears it
  assign irq_o = status_r && mask_r;

  // configuration fields
  // plain slices, no extra state
  logic       is_input;
  logic [1:0] pull_select;
  logic       irq_edge_mode;
  logic       pin_polarity;
  logic       open_drain_select;
  logic       pin_enable;
  logic [3:0] pin_function_select;

  assign is_input            = gpio6_nv_pin_config_r[gpio_cfg_pkg::DIR_BIT];  // R18
  assign pull_select         = gpio6_nv_pin_config_r[gpio_cfg_pkg::PULL_HI:gpio_cfg_pkg::PULL_LO];
  assign irq_edge_mode       = gpio6_nv_pin_config_r[gpio_cfg_pkg::EDGE_BIT];
  assign pin_polarity        = gpio6_nv_pin_config_r[gpio_cfg_pkg::POL_BIT];
  assign open_drain_select   = gpio6_nv_pin_config_r[gpio_cfg_pkg::OD_BIT];
  assign pin_enable          = gpio6_nv_pin_config_r[gpio_cfg_pkg::ENA_BIT];
  assign pin_function_select = gpio6_nv_pin_config_r[gpio_cfg_pkg::FN_HI:gpio_cfg_pkg::FN_LO];

  // pull and supply controls, registered; reserved pull code enables neither
  // pulls act even on a disabled pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pull_up_en_o           <= 1'b0;
      pull_down_en_o         <= 1'b1;
      supply_domain_select_o <= 1'b0;
    end else begin
      pull_up_en_o           <= (pull_select == gpio_cfg_pkg::PULL_UP);    // R1
      pull_down_en_o         <= (pull_select == gpio_cfg_pkg::PULL_DOWN);  // R1
      supply_domain_select_o <= gpio6_nv_pin_config_r[gpio_cfg_pkg::DOMAIN_BIT]; // R4
    end
  end

  // input path
  // pad, two flops, polarity, filter,
  // then requests and edge events

  // synchroniser stages
  logic pad_meta_r;
  logic pad_sync_r;
  logic osc_meta_r;
  logic osc_sync_r;

  // two-stage synchronisers for the pad and the 32 kHz oscillator
  // only the second stage is ever read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_meta_r <= 1'b0;
      pad_sync_r <= 1'b0;
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
    end else begin
      pad_meta_r <= pad_in_i;
      pad_sync_r <= pad_meta_r;
      osc_meta_r <= osc_32k_i;
      osc_sync_r <= osc_meta_r;
    end
  end

  // filter state
  logic        active_raw;
  logic        deb_r;
  logic [31:0] deb_cnt_r;

  assign active_raw = pin_polarity ? pad_sync_r : !pad_sync_r;  // R5

  // long de-bounce: the level must hold for DEB_CYC cycles before it is taken
  // any return to the old level restarts
  // the count, so bounce never passes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deb_r     <= 1'b0;
      deb_cnt_r <= 32'h0000_0000;
    end else if (active_raw == deb_r) begin
      deb_cnt_r <= 32'h0000_0000;
    end else if (deb_cnt_r >= 32'(DEB_CYC - 1)) begin
      deb_r     <= active_raw;
      deb_cnt_r <= 32'h0000_0000;
    end else begin
      deb_cnt_r <= deb_cnt_r + 32'h0000_0001;
    end
  end

  // request and edge state
  logic use_deb;
  logic in_live;
  logic in_prev_r;

  // codes 0, 4, 14 and 15 look at the filtered level
  // the rest see the raw level
  assign use_deb = (pin_function_select == gpio_cfg_pkg::IN_DEBOUNCED)   // R8
                || (pin_function_select == gpio_cfg_pkg::IN_SW_DEB)      // R10
                || (pin_function_select == gpio_cfg_pkg::IN_CTL1_DEB)    // R17
                || (pin_function_select == gpio_cfg_pkg::IN_CTL2_DEB);
  assign in_level = use_deb ? deb_r : active_raw;
  // a disabled or output pin takes no input
  assign in_live  = in_level && is_input && pin_enable;                  // R7

  // edge detector on the active level
  // tracked while disabled, so enabling
  // the pin reports no edge by itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_prev_r <= 1'b0;
    end else begin
      in_prev_r <= in_level;
    end
  end

  // active level already folds in polarity, so mode 0 is one rising test
  // output or disabled pins set no status
  assign edge_ev = is_input && pin_enable && (irq_edge_mode
                   ? (in_level != in_prev_r)                            // R3
                   : (in_level && !in_prev_r));                         // R2

  // route the active level to the request selected by the function code
  // requests are levels; only the one
  // selected by the code leaves zero;
  // the consumer judges its edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio_in_o             <= 1'b0;
      power_toggle_req_o    <= 1'b0;
      sleep_wake_req_o      <= 1'b0;
      sleep_req_o           <= 1'b0;
      power_on_req_o        <= 1'b0;
      watchdog_reset_o      <= 1'b0;
      voltage_scaling_sel_o <= 2'h0;
      hw_enable_o           <= 2'h0;
      hw_control_o          <= 2'h0;
    end else begin
      gpio_in_o             <= in_live && (pin_function_select <= gpio_cfg_pkg::IN_RAW); // R8
      power_toggle_req_o    <= in_live && (pin_function_select == gpio_cfg_pkg::IN_PWR_TOGGLE); // R9
      sleep_wake_req_o      <= in_live && ((pin_function_select == gpio_cfg_pkg::IN_SLEEP_WAKE)
                                        || (pin_function_select == gpio_cfg_pkg::IN_SW_DEB)); // R9
      sleep_req_o           <= in_live && (pin_function_select == gpio_cfg_pkg::IN_SLEEP);  // R10
      power_on_req_o        <= in_live && (pin_function_select == gpio_cfg_pkg::IN_PWR_ON); // R16
      watchdog_reset_o      <= in_live && (pin_function_select == gpio_cfg_pkg::IN_WDOG);   // R16
      voltage_scaling_sel_o <= {in_live && (pin_function_select == gpio_cfg_pkg::IN_VS2),
                                in_live && (pin_function_select == gpio_cfg_pkg::IN_VS1)}; // R16
      hw_enable_o           <= {in_live && (pin_function_select == gpio_cfg_pkg::IN_HW_EN2),
                                in_live && (pin_function_select == gpio_cfg_pkg::IN_HW_EN1)}; // R17
      hw_control_o          <= {in_live && ((pin_function_select == gpio_cfg_pkg::IN_HW_CTL2)
                                         || (pin_function_select == gpio_cfg_pkg::IN_CTL2_DEB)),
                                in_live && ((pin_function_select == gpio_cfg_pkg::IN_HW_CTL1)
                                         || (pin_function_select == gpio_cfg_pkg::IN_CTL1_DEB))}; // R17
    end
  end

  // output path
  // table, then polarity, then drive style

  // 2 MHz phase accumulator
  logic [gpio_cfg_pkg::ACC_BITS-1:0] phase_r;

  // phase accumulator: msb is a 2 MHz square wave with small jitter,
  // traded for not needing a second clock;
  // the step is rounded, so the rate
  // sits slightly above 2 MHz
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + gpio_cfg_pkg::EXT_CLK_STEP;
    end
  end

  // value chosen by the function code
  logic out_fn_val;

  // output function table; reserved codes drive the inactive level
  // every code is listed, so no default
  always_comb begin
    unique case (pin_function_select)
      gpio_cfg_pkg::OUT_GPIO:     out_fn_val = gpio_out_r;
      gpio_cfg_pkg::OUT_OSC32K:   out_fn_val = osc_sync_r;                    // R11
      gpio_cfg_pkg::OUT_ON_STATE: out_fn_val = on_state_i;                    // R12
      gpio_cfg_pkg::OUT_SLEEP_ST: out_fn_val = sleep_state_i;                 // R12
      gpio_cfg_pkg::OUT_STATE_CH: out_fn_val = state_change_i;                // R12
      gpio_cfg_pkg::OUT_RSV5,
      gpio_cfg_pkg::OUT_RSV6,
      gpio_cfg_pkg::OUT_RSV7:     out_fn_val = 1'b0;                          // R12
      gpio_cfg_pkg::OUT_VS_DONE1: out_fn_val = voltage_scaling_done_i[0];     // R13
      gpio_cfg_pkg::OUT_VS_DONE2: out_fn_val = voltage_scaling_done_i[1];     // R13
      gpio_cfg_pkg::OUT_EXT_EN1:  out_fn_val = ext_power_enable_i[0];         // R13
      gpio_cfg_pkg::OUT_EXT_EN2:  out_fn_val = ext_power_enable_i[1];         // R13
      gpio_cfg_pkg::OUT_SYS_GOOD: out_fn_val = system_supply_good_i;          // R14
      gpio_cfg_pkg::OUT_CONVERTER_POWER_GOOD: out_fn_val = converter_power_good_i;        // R14
      gpio_cfg_pkg::OUT_EXT_CLK:  out_fn_val = phase_r[gpio_cfg_pkg::ACC_BITS-1]; // R15
      gpio_cfg_pkg::OUT_AUX_RST:  out_fn_val = aux_reset_i;                   // R15
    endcase
  end

  // value after polarity
  logic pin_val;

  // polarity applies after the table
  assign pin_val = pin_polarity ? out_fn_val : !out_fn_val;  // R5

  // pad drivers registered; open drain only ever pulls low
  // a one releases the line; the board
  // pull must then bring it high, so a
  // rise is as slow as that pull allows
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_out_o <= 1'b0;
      pad_oe_o  <= 1'b0;
    end else begin
      pad_out_o <= open_drain_select ? 1'b0 : pin_val;             // R6
      pad_oe_o  <= pin_enable && !is_input                         // R7 R18
                && (!open_drain_select || !pin_val);               // R6
    end
  end

endmodule // gpio_pin_nv_config
`default_nettype wire

// file: rtl/gpio_cfg_pkg.sv
// Overview of operation
// [R1] pull field: 00 none, 01 pull-down (default), 10 pull-up, 11 reserved.
// [R2] edge mode 0: interrupt on rising active-level edge, following polarity.
// [R3] edge mode 1: interrupt on both pin edges, polarity ignored.
// [R4] supply domain bit: 0 io buffer supply (default), 1 main system supply.
// [R5] polarity bit 1 active high (default), 0 inverted active low.
// [R6] output type bit 0 push-pull (default), 1 open drain.
// [R7] enable bit 0 holds pin tri-stated (default), 1 normal operation.
// [R8] input code 0 debounced plain input, code 1 plain raw input.
// [R9] input code 2 power on/off request, code 3 sleep/wake request.
// [R10] input code 4 debounced sleep/wake request, code 5 sleep-only request.
// [R11] output code 1 drives the 32.768 kHz oscillator clock.
// [R12] output codes 2,3,4: ON state, SLEEP state, state change; 5-7 reserved.
// [R13] output codes 8,9 scaling done per buck; 10,11 external power enables.
// [R14] output code 12 system supply good, code 13 converter power good.
// [R15] output code 14 external 2 MHz power clock, code 15 auxiliary reset.
// [R16] input codes 6 power-on, 7 watchdog reset, 8/9 voltage scaling selects.
// [R17] input codes 10/11 hw enables, 12/13 hw controls, 14/15 debounced controls.
// [R18] direction bit 0 output, 1 input (default); selects function table.
package gpio_cfg_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] CFG_IDX    = 16'h781f;
  localparam logic [15:0] STATUS_IDX = 16'h7840;
  localparam logic [15:0] MASK_IDX   = 16'h7841;
  localparam logic [15:0] DATA_IDX   = 16'h7842;

  // configuration field positions
  localparam int DIR_BIT      = 15;
  localparam int PULL_HI      = 14;
  localparam int PULL_LO      = 13;
  localparam int EDGE_BIT     = 12;
  localparam int DOMAIN_BIT   = 11;
  localparam int POL_BIT      = 10;
  localparam int OD_BIT       = 9;
  localparam int ENA_BIT      = 8;
  localparam int FN_HI        = 7;
  localparam int FN_LO        = 4;

  // reset value and writable bits; bits 3:0 are not held here and read zero
  localparam logic [15:0] CFG_RESET  = 16'ha400;
  localparam logic [15:0] CFG_WMASK  = 16'hfff0;

  // pull encodings
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP   = 2'h2;

  // status / mask / data bit positions
  localparam int EDGE_EV_BIT  = 0;
  localparam int DATA_OUT_BIT = 0;
  localparam int DATA_IN_BIT  = 1;

  // input function codes
  typedef enum logic [3:0] {
    IN_DEBOUNCED = 4'h0, IN_RAW      = 4'h1, IN_PWR_TOGGLE = 4'h2, IN_SLEEP_WAKE = 4'h3,
    IN_SW_DEB    = 4'h4, IN_SLEEP    = 4'h5, IN_PWR_ON     = 4'h6, IN_WDOG       = 4'h7,
    IN_VS1       = 4'h8, IN_VS2      = 4'h9, IN_HW_EN1     = 4'ha, IN_HW_EN2     = 4'hb,
    IN_HW_CTL1   = 4'hc, IN_HW_CTL2  = 4'hd, IN_CTL1_DEB   = 4'he, IN_CTL2_DEB   = 4'hf
  } in_fn_t;

  // output function codes
  typedef enum logic [3:0] {
    OUT_GPIO     = 4'h0, OUT_OSC32K  = 4'h1, OUT_ON_STATE  = 4'h2, OUT_SLEEP_ST  = 4'h3,
    OUT_STATE_CH = 4'h4, OUT_RSV5    = 4'h5, OUT_RSV6      = 4'h6, OUT_RSV7      = 4'h7,
    OUT_VS_DONE1 = 4'h8, OUT_VS_DONE2 = 4'h9, OUT_EXT_EN1  = 4'ha, OUT_EXT_EN2   = 4'hb,
    OUT_SYS_GOOD = 4'hc, OUT_CONVERTER_POWER_GOOD = 4'hd, OUT_EXT_CLK  = 4'he, OUT_AUX_RST   = 4'hf
  } out_fn_t;

  // timing
  localparam longint CLK_HZ          = 125_000_000;
  localparam int     LONG_DEB_MS     = 2;
  localparam int     LONG_DEB_CYC    = int'(CLK_HZ / 1000) * LONG_DEB_MS;
  localparam longint EXT_CLK_HZ      = 2_000_000;
  localparam int     ACC_BITS        = 16;
  // phase step of the 2 MHz generator, rounded to nearest
  localparam logic [15:0] EXT_CLK_STEP =
    16'((EXT_CLK_HZ * 64'd65536 + CLK_HZ / 2) / CLK_HZ);

endpackage

// file: tb/gpio_pin_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module gpio_pin_monitor #(
  parameter int DEB_CYC = 4
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [17:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        irq_o,
  input wire logic        pad_in_i,
  input wire logic        pad_oe_o,
  input wire logic        pull_up_en_o,
  input wire logic        pull_down_en_o,
  input wire logic        supply_domain_select_o,
  input wire logic        gpio_in_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        take;
  logic        cfg_wr;
  logic        unmapped;
  logic        pad_q_r;
  logic [31:0] quiet_r;
  // decode of the bus request as the slave sees it
  assign take = cyc_i && stb_i && !ack_o;
  assign cfg_wr = take && we_i && sel_i[1] && adr_i[17:2] == gpio_cfg_pkg::CFG_IDX;
  assign unmapped = !(adr_i[17:2] inside {gpio_cfg_pkg::CFG_IDX, gpio_cfg_pkg::STATUS_IDX,
                                          gpio_cfg_pkg::MASK_IDX, gpio_cfg_pkg::DATA_IDX});
  // cycles since the pad or a register last moved; an event long after both is spurious
  always_ff @(posedge clk_i) begin
    pad_q_r <= pad_in_i;
    if (rst_i || pad_in_i != pad_q_r || (take && we_i)) quiet_r <= '0;
    else if (quiet_r < 32'd1000) quiet_r <= quiet_r + 32'd1;
  end
  chk_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_latency: assert property (take |=> ack_o)
    else $error("ack missing one cycle after request");
  chk_reset_state: assert property ($past(rst_i) |-> pull_down_en_o && !pull_up_en_o &&
    !pad_oe_o && !irq_o && !supply_domain_select_o)
    else $error("outputs not at reset values");
  chk_unmapped_zero: assert property ($past(take && !we_i && unmapped) |-> ack_o && dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_pull_follow: assert property (cfg_wr && dat_i[14:13] != 2'h3 |=> ##1
    pull_up_en_o == $past(dat_i[14], 2) && pull_down_en_o == $past(dat_i[13], 2))
    else $error("pull enables do not follow field");
  chk_supply_follow: assert property (cfg_wr |=> ##1
    supply_domain_select_o == $past(dat_i[11], 2))
    else $error("supply select does not follow bit");
  chk_disable_tristate: assert property (cfg_wr && !dat_i[8] |=> ##1 !pad_oe_o)
    else $error("disabled pin is driven");
  chk_irq_cause: assert property ($rose(irq_o) |-> ack_o || quiet_r < DEB_CYC + 8)
    else $error("interrupt rose with no cause");
  chk_out_no_request: assert property (pad_oe_o && $past(pad_oe_o) |-> !gpio_in_o)
    else $error("input request while pin drives");
endmodule // gpio_pin_monitor
`default_nettype wire

// file: tb/pin_board.sv
`timescale 1ns/1ns
`default_nettype none
// board side of the pin: an optional external driver and the selected pull
module pin_board (
  input  wire logic clk_i,
  input  wire logic out_i,
  input  wire logic oe_i,
  input  wire logic pu_i,
  input  wire logic pd_i,
  input  wire logic ext_en_i,
  input  wire logic ext_val_i,
  output logic      pad_o
);
  logic flip_r = 1'b0;
  // a floating pin must not settle to a lucky value, so it wanders each cycle
  always_ff @(posedge clk_i) flip_r <= ~flip_r;
  assign pad_o = oe_i ? out_i : ext_en_i ? ext_val_i : pu_i ? 1'b1 : pd_i ? 1'b0 : flip_r;
endmodule // pin_board
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
  localparam int DEB = 4;
  localparam logic [15:0] CFG = gpio_cfg_pkg::CFG_IDX;
  localparam logic [15:0] STA = gpio_cfg_pkg::STATUS_IDX;
  // mask, edge mode, polarity, start level, end level, event expected
  localparam logic [5:0] EDGE_TAB [9] = '{6'h33, 6'h26, 6'h25, 6'h22, 6'h3b, 6'h3d,
                                          6'h2b, 6'h35, 6'h13};
  localparam int REQ_BIT [16] = '{0, 0, 1, 2, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 10, 11};
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ext_en = 0, ext_val = 0;
  logic [17:0] adr_i = '0;
  logic [3:0] sel_i = '0;
  logic [31:0] dat_i = '0, dat_o, exp_v;
  logic [15:0] src_r = '0, r = 16'hbd6c;
  logic ack_o, irq_o, pad_in_i, pad_out_o, pad_oe_o, pu_o, pd_o, dom_o, gin_o, tog_o, sw_o, sl_o;
  logic pon_o, wd_o, last;
  logic [1:0] vs_o, hwe_o, hwc_o;
  logic [11:0] reqs, exp_req;
  logic [31:0] exp_q[$];
  int n_fail = 0, checks_done = 0, n;
  assign reqs = {hwc_o, hwe_o, vs_o, wd_o, pon_o, sl_o, sw_o, tog_o, gin_o};
  gpio_pin_nv_config #(.DEB_CYC(DEB)) gpio_pin_nv_config_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o), .pull_up_en_o(pu_o), .pull_down_en_o(pd_o),
    .supply_domain_select_o(dom_o), .osc_32k_i(src_r[1]), .on_state_i(src_r[2]),
    .sleep_state_i(src_r[3]), .state_change_i(src_r[4]), .voltage_scaling_done_i(src_r[9:8]),
    .ext_power_enable_i(src_r[11:10]), .system_supply_good_i(src_r[12]),
    .converter_power_good_i(src_r[13]), .aux_reset_i(src_r[15]), .gpio_in_o(gin_o),
    .power_toggle_req_o(tog_o), .sleep_wake_req_o(sw_o), .sleep_req_o(sl_o),
    .power_on_req_o(pon_o), .watchdog_reset_o(wd_o), .voltage_scaling_sel_o(vs_o),
    .hw_enable_o(hwe_o), .hw_control_o(hwc_o));
  pin_board pin_board_i (.clk_i(clk_i), .out_i(pad_out_o), .oe_i(pad_oe_o), .pu_i(pu_o),
    .pd_i(pd_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad_in_i));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [31:0] cfg(logic dir, logic [1:0] pl, logic ed, logic dm, logic pol,
                                      logic od, logic en, logic [3:0] fn);
    return {16'h0, dir, pl, ed, dm, pol, od, en, fn, 4'h0};
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // one classic cycle; the request stands until ack is seen at an edge
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'h0};
    sel_i <= 4'h3;
    dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 40);
    if (k >= 40) n_fail++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, idx, 32'h0);
  endtask
  // one edge on the pad with a given mode, checked at irq and in the sticky status
  task automatic edge_chk(input logic [5:0] t);
    ext_val <= t[2];
    bus(1'b1, gpio_cfg_pkg::MASK_IDX, {31'h0, t[5]});
    bus(1'b1, CFG, cfg(1, 0, t[4], 0, t[3], 0, 1, 4'h1));
    tick(8);
    bus(1'b1, STA, 32'h1);
    ext_val <= t[1];
    tick(8);
    `CHK("irq", t[0] & t[5], irq_o)
    rd(STA, {31'h0, t[0]});
    bus(1'b1, STA, 32'h1);
    tick(1);
    `CHK("irq_clear", 1'b0, irq_o)
  endtask
  // reads are judged when their answer appears, oldest note first
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      `CHK("read", exp_v, dat_o)
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    tick(40000);
    n_fail++;
    wrap_up();
  end
  initial begin
    tick(5);
    rst_i <= 1'b0;
    ext_en <= 1'b1;
    rd(CFG, 32'ha400);
    rd(16'h0123, 32'h0);
    for (int p = 0; p < 3; p++) begin
      bus(1'b1, CFG, cfg(1, p[1:0], 0, p[0], 1, 0, 0, 0));
      tick(2);
      `CHK("pull", {p == 2, p == 1, p[0]}, {pu_o, pd_o, dom_o})
    end
    for (int c = 0; c < 16; c++) begin
      r = lfsr(r);
      src_r <= r;
      bus(1'b1, gpio_cfg_pkg::DATA_IDX, {31'h0, r[0]});
      bus(1'b1, CFG, cfg(0, 0, 0, 0, 1, 0, 1, c[3:0]));
      tick(3);
      if (c != 14) `CHK("fn_out", (c inside {5, 6, 7}) ? 1'b0 : r[c], pad_out_o)
      `CHK("cmos_oe", 1'b1, pad_oe_o)
    end
    bus(1'b1, CFG, cfg(0, 0, 0, 0, 1, 0, 1, 4'he));
    tick(2);
    n = 0;
    last = pad_out_o;
    repeat (100) begin
      @(posedge clk_i);
      if (pad_out_o !== last) n++;
      last = pad_out_o;
    end
    `CHK("clk_2m", 1'b1, n >= 3 && n <= 4)
    bus(1'b1, gpio_cfg_pkg::DATA_IDX, 32'h1);
    bus(1'b1, CFG, cfg(0, 0, 0, 0, 0, 0, 1, 0));
    tick(3);
    `CHK("inverted", 1'b0, pad_out_o)
    bus(1'b1, CFG, cfg(0, 0, 0, 0, 1, 1, 1, 0));
    tick(3);
    `CHK("od_off", 1'b0, pad_oe_o)
    bus(1'b1, gpio_cfg_pkg::DATA_IDX, 32'h0);
    tick(3);
    `CHK("od_sink", 2'h1, {pad_out_o, pad_oe_o})
    bus(1'b1, CFG, cfg(0, 0, 0, 0, 1, 0, 0, 0));
    tick(3);
    `CHK("tristate", 1'b0, pad_oe_o)
    for (int c = 0; c < 20; c++) begin
      bus(1'b1, CFG, cfg(1, 0, 0, 0, c < 18, 0, c < 16 || c > 17, c[3:0]));
      for (int v = 0; v < 2; v++) begin
        ext_val <= v[0];
        tick(5);
        // raw codes have moved by now, filtered ones not yet
        exp_req = (c inside {0, 4, 14, 15}) ? 12'h0 : 12'h1 << REQ_BIT[c[3:0]];
        if (v == 1 && c < 16) `CHK("deb_hold", exp_req, reqs)
        tick(DEB + 3);
        exp_req = (v[0] ^ (c > 17)) && (c < 16 || c > 17) ? 12'h1 << REQ_BIT[c[3:0]] : 12'h0;
        `CHK("request", exp_req, reqs)
      end
    end
    for (int i = 0; i < 9; i++) edge_chk(EDGE_TAB[i]);
    wrap_up();
  end
endmodule // tb_top
bind gpio_pin_nv_config gpio_pin_monitor #(.DEB_CYC(DEB_CYC)) mon_i (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .pad_in_i(pad_in_i),
  .pad_oe_o(pad_oe_o), .pull_up_en_o(pull_up_en_o), .pull_down_en_o(pull_down_en_o),
  .supply_domain_select_o(supply_domain_select_o), .gpio_in_o(gpio_in_o));
`default_nettype wire
